// ==== hw/sfw_defines.vh ====
/*
 * register offsets, field positions, reset values and buffer sizes for
 * the sector fifo write-commit block.
 * assumes: included by its bare name from the design file.
 */
`ifndef SFW_DEFINES_VH
`define SFW_DEFINES_VH

// printed register offsets (not multiples of four: kept as indexes)
`define SFW_IDX_WPTR_LO 16'hF0EB
`define SFW_IDX_WPTR_HI 16'hF0EC
`define SFW_IDX_CPTR_LO 16'hF0ED
`define SFW_IDX_CPTR_HI 16'hF0EE
`define SFW_IDX_XCNT 16'hF0F9
// own registers (indexes)
`define SFW_IDX_STATUS 16'hF0E0
`define SFW_IDX_CTRL 16'hF0E1
`define SFW_IDX_IMASK 16'hF0E2
`define SFW_IDX_ISTAT 16'hF0E3
// status register bit positions
`define SFW_BIT_OVF 4
`define SFW_BIT_SYNC 5
`define SFW_BIT_EXTRA 6
// control register bit positions
`define SFW_BIT_SOFT_RST 0
`define SFW_BIT_FIFO_CLR 1
`define SFW_BIT_START 2
// high byte empty flag position
`define SFW_BIT_EMPTY 7
// interrupt bit positions
`define SFW_INT_OVF 0
`define SFW_INT_SYNC 1
`define SFW_INT_EXTRA 2
// sizes and resets
`define SFW_PTR_W 14
`define SFW_PTR_RST 14'h0000
`define SFW_SIDE_BUF_BYTES 4'h6
`define SFW_XCNT_RST 4'h0
`define SFW_BYTE_RST 8'h00
// axi responses
`define SFW_RESP_OK 2'h0
`define SFW_RESP_SLVERR 2'h2

`endif

// ==== hw/sfw_top.v ====
/*
 * sector fifo write side with commit/rewind pointers, udma receive error
 * flags, extra-word counter, interrupt status/mask and axi4-lite slave.
 * assumes: all event inputs are synchronous one-cycle pulses from logic on
 * sys_clk_in; the read side keeps its own pointers and obeys rd_limit_out.
 */
`timescale 1ns/100ps
`include "sfw_defines.vh"

// register map, byte address is four times the index, data in bits 7:0
//   F0EB  working write pointer, bits 7:0, read only
//   F0EC  empty flag in bit 7, bit 6 zero, working pointer 13:8 in 5:0
//   F0ED  confirmed write pointer, bits 7:0, read only
//   F0EE  confirmed write pointer 13:8 in bits 5:0, bits 7:6 zero
//   F0F9  extra word count in bits 3:0, wraps at sixteen
//   F0E0  status: bit 4 overflow, bit 5 sync overrun, bit 6 extra
//   F0E1  control, write only pulses: bit 0 soft reset, bit 1 fifo clear,
//         bit 2 transfer start; reads back as zero
//   F0E2  interrupt mask, bits 2:0
//   F0E3  interrupt status, write one to clear
//         bit 0 overflow, bit 1 sync overrun, bit 2 extra receive
//
// any other address answers slverr, with zero read data
// writes with wstrb[0] low are accepted and ignored
//
// write channel timing
//   edge 0: address and data both taken (either order, the first held)
//   edge 1: bvalid high until bready is seen
//   control pulses stand for the cycle after the take
//   flag clears land on the edge after the pulse
//
// read channel timing
//   edge 0: address taken while no answer is pending
//   edge 1: rvalid high with the byte, until rready is seen
//   the read data is latched at the take, so later pointer moves
//   do not disturb an answer that is already waiting
//
// pointer behaviour
//   a push moves the working pointer one word, wrapping at the top
//   a commit copies the working pointer, including a push of the
//   same cycle, into the confirmed pointer
//   a usb crc error restores the working pointer from the confirmed
//   one and beats any push or commit of the same cycle
//   a fifo clear pulse zeroes both pointers and beats everything
//   the read side never passes the confirmed pointer, so data that
//   was written but not committed stays invisible to it
//
// surplus words
//   a surplus word is never written; it sets the extra flag and interrupt
//   status bit 2, and bumps the extra word count
//   the crc engine keeps running for as long as the udma read runs,
//   so surplus data still counts toward the crc
//
// error flags
//   every flag is sticky; an event of the same cycle as a clear wins,
//   so no error is ever lost to a clear that races it
//   soft reset and transfer start both clear the status flags, the
//   side buffer count and the extra word count
//   the side buffer holds six bytes; the seventh one since the last
//   clear is an overflow
//
// hazards
//   all event inputs must be single-cycle pulses on sys_clk_in; a
//   level would count once per cycle
//   the empty flag is taken from the read side as it stands; this
//   block keeps no copy of it
//   firmware must clear the fifo before a data command whenever the
//   empty flag reads back low
//

module sfw_top (
    input wire sys_clk_in,
    input wire rstn_in,
    // data path events from the usb manager and ata engine
    input wire wr_push_in,
    input wire wr_commit_in,
    input wire wr_crc_err_in,
    input wire surplus_word_in,
    input wire side_byte_in,
    input wire sync_overrun_in,
    input wire udma_active_in,
    input wire fifo_empty_in,
    output wire [13:0] working_write_pointer_out,
    output wire [13:0] rd_limit_out,
    output wire fifo_clear_out,
    output wire crc_accum_out,
    output wire surplus_drop_out,
    output wire irq_out,
    // axi4-lite slave
    input wire [17:0] s_axi_awaddr,
    input wire s_axi_awvalid,
    output wire s_axi_awready,
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    output wire s_axi_wready,
    output wire [1:0] s_axi_bresp,
    output wire s_axi_bvalid,
    input wire s_axi_bready,
    input wire [17:0] s_axi_araddr,
    input wire s_axi_arvalid,
    output wire s_axi_arready,
    output wire [31:0] s_axi_rdata,
    output wire [1:0] s_axi_rresp,
    output wire s_axi_rvalid,
    input wire s_axi_rready
);

    // byte address from register index
    function [17:0] sfw_addr;
        input [15:0] idx;
        begin
            sfw_addr = {idx, 2'b00};
        end
    endfunction

    // true when address names a known register
    function sfw_mapped;
        input [17:0] a;
        begin
            sfw_mapped = (a == sfw_addr(`SFW_IDX_WPTR_LO)) ||
                (a == sfw_addr(`SFW_IDX_WPTR_HI)) ||
                (a == sfw_addr(`SFW_IDX_CPTR_LO)) ||
                (a == sfw_addr(`SFW_IDX_CPTR_HI)) ||
                (a == sfw_addr(`SFW_IDX_XCNT)) ||
                (a == sfw_addr(`SFW_IDX_STATUS)) ||
                (a == sfw_addr(`SFW_IDX_CTRL)) ||
                (a == sfw_addr(`SFW_IDX_IMASK)) ||
                (a == sfw_addr(`SFW_IDX_ISTAT));
        end
    endfunction

    reg [13:0] wptr_r;
    reg [13:0] cptr_r;
    reg [3:0] side_cnt_r;
    reg [3:0] xcnt_r;
    reg ovf_r;
    reg sync_r;
    reg extra_r;
    reg [2:0] istat_r;
    reg [2:0] imask_r;
    reg soft_rst_r;
    reg fifo_clr_r;
    reg start_r;
    reg aw_hold_r;
    reg w_hold_r;
    reg [17:0] awaddr_r;
    reg [31:0] wdata_r;
    reg wstrb0_r;
    reg bvalid_r;
    reg [1:0] bresp_r;
    reg rvalid_r;
    reg [31:0] rdata_r;
    reg [1:0] rresp_r;
    reg [7:0] rd_byte;

    wire wr_go;
    wire ctrl_wr;
    wire istat_wr;
    wire imask_wr;
    wire flag_clr;
    wire ovf_evt;
    wire [2:0] evt;
    wire [17:0] wa;
    wire [31:0] wd;
    wire ws0;

    // write channel capture in either order
    assign s_axi_awready = !aw_hold_r && !bvalid_r;
    assign s_axi_wready = !w_hold_r && !bvalid_r;
    assign wa = aw_hold_r ? awaddr_r : s_axi_awaddr;
    assign wd = w_hold_r ? wdata_r : s_axi_wdata;
    assign ws0 = w_hold_r ? wstrb0_r : s_axi_wstrb[0];
    assign wr_go = (aw_hold_r || (s_axi_awvalid && s_axi_awready)) &&
        (w_hold_r || (s_axi_wvalid && s_axi_wready));
    assign ctrl_wr = wr_go && ws0 && (wa == sfw_addr(`SFW_IDX_CTRL));
    assign istat_wr = wr_go && ws0 && (wa == sfw_addr(`SFW_IDX_ISTAT));
    assign imask_wr = wr_go && ws0 && (wa == sfw_addr(`SFW_IDX_IMASK));

    // self-clearing control pulses
    assign flag_clr = soft_rst_r || start_r;
    assign fifo_clear_out = fifo_clr_r;

    always @(posedge sys_clk_in) begin
        if (!rstn_in) begin
            aw_hold_r <= 1'b0;
            w_hold_r <= 1'b0;
            awaddr_r <= 18'h00000;
            wdata_r <= 32'h00000000;
            wstrb0_r <= 1'b0;
            bvalid_r <= 1'b0;
            bresp_r <= `SFW_RESP_OK;
        end else begin
            if (wr_go) begin
                aw_hold_r <= 1'b0;
                w_hold_r <= 1'b0;
                bvalid_r <= 1'b1;
                bresp_r <= sfw_mapped(wa) ? `SFW_RESP_OK : `SFW_RESP_SLVERR;
            end else begin
                if (s_axi_awvalid && s_axi_awready) begin
                    aw_hold_r <= 1'b1;
                    awaddr_r <= s_axi_awaddr;
                end
                if (s_axi_wvalid && s_axi_wready) begin
                    w_hold_r <= 1'b1;
                    wdata_r <= s_axi_wdata;
                    wstrb0_r <= s_axi_wstrb[0];
                end
            end
            if (bvalid_r && s_axi_bready) begin
                bvalid_r <= 1'b0;
            end
        end
    end

    // control pulses and interrupt mask
    always @(posedge sys_clk_in) begin
        if (!rstn_in) begin
            soft_rst_r <= 1'b0;
            fifo_clr_r <= 1'b0;
            start_r <= 1'b0;
            imask_r <= 3'h0;
        end else begin
            soft_rst_r <= ctrl_wr && wd[`SFW_BIT_SOFT_RST];
            fifo_clr_r <= ctrl_wr && wd[`SFW_BIT_FIFO_CLR];
            start_r <= ctrl_wr && wd[`SFW_BIT_START];
            if (imask_wr) begin
                imask_r <= wd[2:0];
            end
        end
    end

    // write pointer: clear, rewind, commit, advance with wrap
    always @(posedge sys_clk_in) begin
        if (!rstn_in) begin
            wptr_r <= `SFW_PTR_RST;
            cptr_r <= `SFW_PTR_RST;
        end else if (fifo_clr_r) begin
            wptr_r <= `SFW_PTR_RST;
            cptr_r <= `SFW_PTR_RST;
        end else if (wr_crc_err_in) begin
            wptr_r <= cptr_r;
        end else begin
            if (wr_push_in && !surplus_word_in) begin
                wptr_r <= wptr_r + 14'h0001;
            end
            if (wr_commit_in) begin
                cptr_r <= (wr_push_in && !surplus_word_in) ?
                    wptr_r + 14'h0001 : wptr_r;
            end
        end
    end

    // read side sees only confirmed data
    assign rd_limit_out = cptr_r;
    assign working_write_pointer_out = wptr_r;
    // surplus words are dropped, crc still runs during udma
    assign surplus_drop_out = surplus_word_in;
    assign crc_accum_out = udma_active_in;

    // error flags, set wins over clear
    assign ovf_evt = side_byte_in && (side_cnt_r >= `SFW_SIDE_BUF_BYTES);
    always @(posedge sys_clk_in) begin
        if (!rstn_in) begin
            side_cnt_r <= 4'h0;
            ovf_r <= 1'b0;
            sync_r <= 1'b0;
            extra_r <= 1'b0;
            xcnt_r <= `SFW_XCNT_RST;
        end else begin
            // a byte arriving with the clear is still counted
            if (flag_clr) begin
                side_cnt_r <= side_byte_in ? 4'h1 : 4'h0;
            end else if (side_byte_in && side_cnt_r != 4'hF) begin
                side_cnt_r <= side_cnt_r + 4'h1;
            end
            ovf_r <= ovf_evt || (ovf_r && !flag_clr);
            sync_r <= sync_overrun_in || (sync_r && !flag_clr);
            extra_r <= surplus_word_in || (extra_r && !flag_clr);
            if (surplus_word_in) begin
                xcnt_r <= (flag_clr ? 4'h0 : xcnt_r) + 4'h1;
            end else if (flag_clr) begin
                xcnt_r <= `SFW_XCNT_RST;
            end
        end
    end

    // sticky interrupt status, write one clears, set wins
    assign evt = {surplus_word_in, sync_overrun_in, ovf_evt};
    genvar gi;
    generate
        for (gi = 0; gi < 3; gi = gi + 1) begin : g_irq
            always @(posedge sys_clk_in) begin
                if (!rstn_in) begin
                    istat_r[gi] <= 1'b0;
                end else begin
                    istat_r[gi] <= evt[gi] ||
                        (istat_r[gi] && !(istat_wr && wd[gi]));
                end
            end
        end
    endgenerate
    assign irq_out = |(istat_r & imask_r);

    // read data mux
    always @* begin
        rd_byte = `SFW_BYTE_RST;
        case (s_axi_araddr)
            sfw_addr(`SFW_IDX_WPTR_LO): rd_byte = wptr_r[7:0];
            sfw_addr(`SFW_IDX_WPTR_HI): begin
                rd_byte = {fifo_empty_in, 1'b0, wptr_r[13:8]};
            end
            sfw_addr(`SFW_IDX_CPTR_LO): rd_byte = cptr_r[7:0];
            sfw_addr(`SFW_IDX_CPTR_HI): rd_byte = {2'b00, cptr_r[13:8]};
            sfw_addr(`SFW_IDX_XCNT): rd_byte = {4'h0, xcnt_r};
            sfw_addr(`SFW_IDX_STATUS): begin
                rd_byte = {1'b0, extra_r, sync_r, ovf_r, 4'h0};
            end
            sfw_addr(`SFW_IDX_IMASK): rd_byte = {5'h00, imask_r};
            sfw_addr(`SFW_IDX_ISTAT): rd_byte = {5'h00, istat_r};
            default: rd_byte = `SFW_BYTE_RST;
        endcase
    end

    // read channel, one cycle to answer
    assign s_axi_arready = !rvalid_r;
    always @(posedge sys_clk_in) begin
        if (!rstn_in) begin
            rvalid_r <= 1'b0;
            rdata_r <= 32'h00000000;
            rresp_r <= `SFW_RESP_OK;
        end else if (s_axi_arvalid && s_axi_arready) begin
            rvalid_r <= 1'b1;
            rdata_r <= {24'h000000, rd_byte};
            rresp_r <= sfw_mapped(s_axi_araddr) ?
                `SFW_RESP_OK : `SFW_RESP_SLVERR;
        end else if (rvalid_r && s_axi_rready) begin
            rvalid_r <= 1'b0;
        end
    end

    assign s_axi_bvalid = bvalid_r;
    assign s_axi_bresp = bresp_r;
    assign s_axi_rvalid = rvalid_r;
    assign s_axi_rdata = rdata_r;
    assign s_axi_rresp = rresp_r;

endmodule // sfw_top

// ==== testbench/sfw_sva.sv ====
/* checker for sfw_top write pointers and event outputs.
   assumes one clock and a synchronous active-low reset. */
`timescale 1ns/100ps
module sfw_chk (
    input wire sys_clk_in,
    input wire rstn_in,
    input wire wr_push_in,
    input wire wr_commit_in,
    input wire wr_crc_err_in,
    input wire surplus_word_in,
    input wire udma_active_in,
    input wire [13:0] working_write_pointer_out,
    input wire [13:0] rd_limit_out,
    input wire fifo_clear_out,
    input wire crc_accum_out,
    input wire surplus_drop_out
);
    default clocking @(posedge sys_clk_in); endclocking
    default disable iff (!rstn_in);
    // no clear pulse under way
    wire nc = !fifo_clear_out;
    // pointer movement
    property p_push; wr_push_in && !surplus_word_in && !wr_crc_err_in && nc |=>
        working_write_pointer_out == $past(working_write_pointer_out) + 14'h1; endproperty
    a_push: assert property (p_push) else $error("push step");
    property p_crc; wr_crc_err_in && nc |=>
        working_write_pointer_out == $past(rd_limit_out); endproperty
    a_crc: assert property (p_crc) else $error("no rewind");
    property p_cmt; wr_commit_in && !wr_crc_err_in && nc |=>
        rd_limit_out == working_write_pointer_out; endproperty
    a_cmt: assert property (p_cmt) else $error("no commit");
    property p_hide; !wr_commit_in && nc |=>
        $stable(rd_limit_out); endproperty
    a_hide: assert property (p_hide) else $error("limit moved");
    // surplus words and crc span
    property p_drop; surplus_word_in && !wr_push_in && !wr_crc_err_in && nc
        |-> surplus_drop_out ##1 $stable(working_write_pointer_out); endproperty
    a_drop: assert property (p_drop) else $error("surplus kept");
    property p_mir; crc_accum_out == udma_active_in; endproperty
    a_mir: assert property (p_mir) else $error("crc span");
    // clear pulse
    property p_clr; fifo_clear_out && !(wr_push_in || wr_commit_in ||
        wr_crc_err_in) |=> working_write_pointer_out == 14'h0 && rd_limit_out == 14'h0;
    endproperty
    a_clr: assert property (p_clr) else $error("clear failed");
    property p_pulse; fifo_clear_out |=> !fifo_clear_out; endproperty
    a_pulse: assert property (p_pulse) else $error("clear too long");
endmodule // sfw_chk
bind sfw_top sfw_chk chk (.*);

// ==== testbench/sfw_peer.sv ====
/* event source standing in for the usb manager and udma engine.
   assumes the bench calls send() between register accesses. */
`timescale 1ns/100ps
module sfw_peer (
    input wire clk_in,
    input wire [13:0] limit_in,
    output wire [6:0] ev_out,
    output wire empty_out
);
    logic [5:0] ev_r = 6'h0;
    logic ud_r = 1'b0;
    integer seed = 32'hE191BDEC;
    // nothing read out, so empty means nothing confirmed
    assign empty_out = limit_in == 14'h0;
    assign ev_out = {ud_r, ev_r};
    // one pulse per unit, sometimes an idle cycle between
    task send(input int b, input int n);
        begin
            ud_r <= b > 2; // surplus, side bytes and sync overruns only in udma reads
            repeat (n) begin
                ev_r[b] <= 1'b1;
                @(posedge clk_in);
                if ($random(seed) & 1) begin
                    ev_r[b] <= 1'b0;
                    @(posedge clk_in);
                end
            end
            ev_r[b] <= 1'b0;
            ud_r <= 1'b0;
            @(posedge clk_in);
        end
    endtask
endmodule // sfw_peer

// ==== testbench/sfw_top_bench.sv ====
/* self-checking bench for sfw_top: axi4-lite tasks, event peer,
   queued answers. assumes one 10 MHz clock. */
`timescale 1ns/100ps
module sfw_top_bench;
    logic sys_clk_in = 1'b0;
    logic rstn_in = 1'b0;
    logic [17:0] s_axi_awaddr = 18'h0, s_axi_araddr = 18'h0;
    logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
    logic s_axi_arvalid = 0, s_axi_rready = 0;
    logic [31:0] s_axi_wdata = 32'h0;
    logic [3:0] s_axi_wstrb = 4'hF;
    wire s_axi_awready, s_axi_wready, s_axi_bvalid;
    wire s_axi_arready, s_axi_rvalid;
    wire [1:0] s_axi_bresp, s_axi_rresp;
    wire [31:0] s_axi_rdata;
    wire wr_push_in, wr_commit_in, wr_crc_err_in, surplus_word_in;
    wire side_byte_in, sync_overrun_in, udma_active_in, fifo_empty_in;
    wire [13:0] working_write_pointer_out, rd_limit_out;
    wire fifo_clear_out, crc_accum_out, surplus_drop_out, irq_out;
    integer seed = 32'hE191BDEC;
    integer error_cnt = 0, compares = 0, cyc = 0, tn = 0, n;
    logic [13:0] wp = 14'h0, cp = 14'h0;
    logic [33:0] q[$];
    sfw_top uut (.*);
    sfw_peer peer (.clk_in(sys_clk_in), .limit_in(rd_limit_out),
        .ev_out({udma_active_in, sync_overrun_in, side_byte_in,
        surplus_word_in, wr_crc_err_in, wr_commit_in, wr_push_in}),
        .empty_out(fifo_empty_in));
    always #50 sys_clk_in = ~sys_clk_in;
    // compare and count
    task chk(input [33:0] seen, input [33:0] exp);
        begin
            compares++;
            if (seen !== exp) begin
                error_cnt++;
                $display("unexpected at %0t: %h want %h", $time, seen, exp);
            end
        end
    endtask
    task tend;
        begin
            tn++;
            $display("test %0d done", tn);
        end
    endtask
    task summarize;
        begin
            $display("compares %0d errors %0d", compares, error_cnt);
            if (error_cnt == 0 && compares > 0)
                $display("SIMULATION PASSED");
            else
                $display("SIMULATION FAILED");
            $finish;
        end
    endtask
    // one register access; the expected answer is queued first
    task xf(input bit w, input [15:0] i, input [31:0] e, input [1:0] r);
        begin
            q.push_back({r, w ? 32'h0 : e});
            @(posedge sys_clk_in);
            s_axi_awaddr <= {i, 2'h0};
            s_axi_araddr <= {i, 2'h0};
            s_axi_wdata <= e;
            s_axi_awvalid <= w;
            s_axi_wvalid <= w;
            s_axi_bready <= w;
            s_axi_arvalid <= !w;
            s_axi_rready <= !w;
            do begin
                @(posedge sys_clk_in);
                if (s_axi_awready) s_axi_awvalid <= 1'b0;
                if (s_axi_wready) s_axi_wvalid <= 1'b0;
                if (s_axi_arready) s_axi_arvalid <= 1'b0;
            end while (!(s_axi_bvalid && s_axi_bready) &&
                !(s_axi_rvalid && s_axi_rready));
            s_axi_bready <= 1'b0;
            s_axi_rready <= 1'b0;
        end
    endtask
    // answer watcher
    always @(posedge sys_clk_in)
        if (s_axi_bvalid && s_axi_bready)
            chk({s_axi_bresp, 32'h0}, q.pop_front());
        else if (s_axi_rvalid && s_axi_rready)
            chk({s_axi_rresp, s_axi_rdata}, q.pop_front());
    // both pointers against the model
    task rdp;
        begin
            xf(0, 16'hF0EB, wp[7:0], 0);
            xf(0, 16'hF0EC, {cp == 14'h0, 1'b0, wp[13:8]}, 0);
            xf(0, 16'hF0ED, cp[7:0], 0);
            xf(0, 16'hF0EE, cp[13:8], 0);
        end
    endtask
    task push(input int k);
        begin
            peer.send(0, k);
            wp = wp + k[13:0];
        end
    endtask
    // hang guard
    always @(posedge sys_clk_in) begin
        cyc++;
        if (cyc == 60000) begin
            error_cnt++;
            summarize;
        end
    end
    // main sequence
    initial begin
        repeat (16) @(posedge sys_clk_in);
        rstn_in <= 1'b1;
        rdp;
        xf(0, 16'hF0F9, 0, 0);
        xf(0, 16'hF0E0, 0, 0);
        xf(0, 16'h0100, 0, 2);
        xf(1, 16'h0100, 0, 2);
        tend;
        push(1 + {$random(seed)} % 300);
        rdp;
        peer.send(1, 1);
        cp = wp;
        rdp;
        push(5);
        peer.send(2, 1);
        wp = cp;
        rdp;
        tend;
        for (n = 0; n < 3; n += 2) begin
            xf(1, 16'hF0E2, n, 0);
            peer.send(4, 6);
            xf(0, 16'hF0E0, 0, 0);
            peer.send(4, 1);
            peer.send(5, 1);
            peer.send(3, 3 + n);
            xf(0, 16'hF0E0, 8'h70, 0);
            xf(0, 16'hF0F9, 3 + n, 0);
            rdp;
            chk(irq_out, n != 0);
            xf(1, 16'hF0E1, 1 << n, 0);
            xf(1, 16'hF0E3, 7, 0);
            xf(0, 16'hF0E0, 0, 0);
            chk(irq_out, 0);
            tend;
        end
        push(9);
        peer.send(1, 1);
        cp = wp;
        rdp;
        xf(1, 16'hF0E1, 2, 0);
        wp = 0;
        cp = 0;
        rdp;
        push(16385);
        peer.send(1, 1);
        cp = wp;
        rdp;
        tend;
        summarize;
    end
endmodule // sfw_top_bench
